//--- core/pp_port.sv
/*
 * parallel port: standard, bidirectional and epp 1.9 host-visible registers and handshake.
 * assumes host strobes and peripheral pins are synchronous to clk_in; pads resolve the bus from its enable.
 */
`timescale 1ns/1ns
`include "pp_cfg.svh"

// What this block does
// - data register latches on write, reads pins when direction set in extended mode
// - status read value held during read
// - overrun bit sets on timeout, write-one clears
// - status bits one and two read zero
// - bits three-five reflect fault, online, paper pins
// - bit six ack level, bit seven inverted
// - control bits six, seven fixed zero
// - control bits drive strobe, feed, init, select
// - ack rising edge interrupts when allowed
// - direction bit floats bus only in extended mode; epp cycles obey it unless the strobe bit is set
// - address port runs epp address cycles
// - data port runs epp data cycles
// - offsets five-seven mirror data port; epp only
// - idle epp mode behaves as standard or bidirectional port
// - watchdog aborts slow epp cycle, flags overrun
// - strobe bit forces write direction in cycle
// - direction set turns epp write into read
// - host ready pulled low during epp cycle
// - wait high first: await low before strobing
// - write drives byte, then write indicate with strobe
// - wait release ends strobe, frees host ready
// - read holds ready low until wait released
// - read floats bus, latches byte at strobe end
module pp_port #(
    parameter int TIMEOUT_CYCLES = `PP_TIMEOUT_CYC,
    parameter int BUF_DEPTH = 2
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // mode straps
    input wire logic epp_mode_in,
    input wire logic extended_mode_in,
    // host i/o side
    input wire logic [2:0] host_addr_in,
    input wire logic [7:0] host_bus_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    output logic [7:0] host_bus_out,
    output logic host_ready_out,
    output logic irq_out,
    // port bus, oe low drives
    input wire logic [7:0] port_bus_in,
    output logic [7:0] port_bus_out,
    output logic port_bus_oe_n_out,
    // printer handshake pins
    output logic strobe_out,
    output logic line_feed_out,
    output logic init_out,
    output logic select_in_out,
    output logic write_indicate_out,
    output logic data_strobe_out,
    output logic addr_strobe_out,
    input wire logic fault_in,
    input wire logic printer_online_in,
    input wire logic paper_out_in,
    input wire logic acknowledge_in,
    input wire logic peripheral_not_ready_in,
    input wire logic peripheral_wait_in
);

    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // elaboration stops on sizes the counter or the buffer cannot serve
    if (TIMEOUT_CYCLES < 1 || BUF_DEPTH < 2)
    begin : g_bad_params
        $error("pp_port: unsupported parameter values");
    end

    pp_pkg::pp_state_e state_q;
    logic [7:0] data_q;
    logic [7:0] addr_q;
    logic [7:0] epp_data_q;
    logic [`PP_CT_WIDTH-1:0] ctl_q;
    logic overrun_q;
    logic [7:0] status_hold_q;
    logic rd_n_q;
    logic wr_n_q;
    logic ack_q;
    logic irq_q;
    logic cyc_write_q;
    logic cyc_addr_q;
    logic [7:0] cyc_byte_q;
    logic [CW-1:0] wd_q;
    logic [7:0] host_bus_q;

    // epp read words pass through a small buffer so a slow host read loses none
    logic [7:0] buf_mem [BUF_DEPTH];
    logic [PW:0] buf_cnt_q;
    logic [PW-1:0] buf_wr_q;
    logic [PW-1:0] buf_rd_q;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;

    function automatic logic is_epp_ofs(input logic [2:0] a);
        is_epp_ofs = (a >= `PP_OFS_EPP_ADDR);
    endfunction

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        if (p == PW'(BUF_DEPTH - 1))
            ptr_next = '0;
        else
            ptr_next = p + PW'(1);
    endfunction

    logic rd_start;
    logic wr_start;
    logic wr_end;
    logic epp_hit;
    logic rd_active;
    logic dir_in;
    logic in_cycle;
    logic cyc_is_write;
    logic timeout;
    logic [7:0] status_live;

    assign rd_start = !host_rd_n_in && rd_n_q;
    assign wr_start = !host_wr_n_in && wr_n_q;
    assign wr_end = host_wr_n_in && !wr_n_q;
    assign rd_active = !host_rd_n_in;
    assign epp_hit = epp_mode_in && is_epp_ofs(host_addr_in);
    assign in_cycle = (state_q != pp_pkg::PP_IDLE) && (state_q != pp_pkg::PP_HOLD);
    assign dir_in = extended_mode_in && ctl_q[`PP_CT_DIR];
    // direction set makes an attempted write run as a read on the cable
    assign cyc_is_write = (cyc_write_q && !ctl_q[`PP_CT_DIR]) || ctl_q[`PP_CT_STROBE];
    assign timeout = in_cycle && (wd_q == '0);

    assign buf_in_valid = (state_q == pp_pkg::PP_STROBE) && peripheral_wait_in && !cyc_is_write;
    assign buf_in_ready = (buf_cnt_q != (PW+1)'(BUF_DEPTH));
    assign buf_out_valid = (buf_cnt_q != '0);
    assign buf_out_ready = (state_q == pp_pkg::PP_DONE) && !cyc_is_write;

    always_comb
    begin
        status_live = 8'h00;
        status_live[`PP_ST_OVERRUN] = overrun_q;
        status_live[`PP_ST_FAULT] = fault_in;
        status_live[`PP_ST_ONLINE] = printer_online_in;
        status_live[`PP_ST_PAPER] = paper_out_in;
        status_live[`PP_ST_ACK] = acknowledge_in;
        status_live[`PP_ST_NOT_READY] = !peripheral_not_ready_in;
    end

    // host strobe edge tracking
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ack_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            rd_n_q <= host_rd_n_in;
            wr_n_q <= host_wr_n_in;
            ack_q <= acknowledge_in;
        end
    end

    // host-written registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            data_q <= `PP_RST_BYTE;
            ctl_q <= `PP_RST_CTL;
            addr_q <= `PP_RST_BYTE;
            epp_data_q <= `PP_RST_BYTE;
        end
        else if (clk_en_in && wr_end)
        begin
            // latching on the trailing edge mirrors the write strobe's rising edge
            if (host_addr_in == `PP_OFS_DATA)
                data_q <= host_bus_in;
            else if (host_addr_in == `PP_OFS_CONTROL)
                ctl_q <= host_bus_in[`PP_CT_WIDTH-1:0];
            else if (epp_hit && host_addr_in == `PP_OFS_EPP_ADDR)
                addr_q <= host_bus_in;
            else if (epp_hit)
                epp_data_q <= host_bus_in;
        end
        else if (clk_en_in && buf_out_valid && buf_out_ready)
        begin
            if (cyc_addr_q)
                addr_q <= buf_mem[buf_rd_q];
            else
                epp_data_q <= buf_mem[buf_rd_q];
        end
    end

    // overrun flag: set wins over write-one clear
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            overrun_q <= 1'b0;
        else if (clk_en_in)
        begin
            if (timeout)
                overrun_q <= 1'b1;
            else if (wr_start && host_addr_in == `PP_OFS_STATUS && host_bus_in[`PP_ST_OVERRUN])
                overrun_q <= 1'b0;
        end
    end

    // interrupt on ack rising edge
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_q <= 1'b0;
        else if (clk_en_in)
        begin
            if (!ctl_q[`PP_CT_IRQ_ALLOW])
                irq_q <= 1'b0;
            else if (acknowledge_in && !ack_q)
                irq_q <= 1'b1;
            else if (rd_start && host_addr_in == `PP_OFS_STATUS)
                irq_q <= 1'b0;
        end
    end

    // epp cycle sequencer
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= pp_pkg::PP_IDLE;
            cyc_write_q <= 1'b0;
            cyc_addr_q <= 1'b0;
            cyc_byte_q <= `PP_RST_BYTE;
        end
        else if (clk_en_in)
        begin
            case (state_q)
                pp_pkg::PP_IDLE:
                    if (epp_hit && (wr_start || rd_start))
                    begin
                        cyc_write_q <= wr_start;
                        cyc_addr_q <= (host_addr_in == `PP_OFS_EPP_ADDR);
                        cyc_byte_q <= host_bus_in;
                        state_q <= pp_pkg::PP_PRE_WAIT;
                    end
                pp_pkg::PP_PRE_WAIT:
                    if (timeout)
                        state_q <= pp_pkg::PP_HOLD;
                    else if (!peripheral_wait_in)
                        state_q <= pp_pkg::PP_STROBE;
                pp_pkg::PP_STROBE:
                    if (timeout)
                        state_q <= pp_pkg::PP_HOLD;
                    else if (peripheral_wait_in && (cyc_is_write || buf_in_ready))
                        state_q <= pp_pkg::PP_DONE;
                pp_pkg::PP_DONE:
                    state_q <= pp_pkg::PP_HOLD;
                pp_pkg::PP_HOLD:
                    if (host_rd_n_in && host_wr_n_in)
                        state_q <= pp_pkg::PP_IDLE;
                default:
                    state_q <= pp_pkg::PP_IDLE;
            endcase
        end
    end

    // watchdog, reloaded whenever no cycle runs
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            wd_q <= CW'(TIMEOUT_CYCLES);
        else if (clk_en_in)
        begin
            if (!in_cycle)
                wd_q <= CW'(TIMEOUT_CYCLES);
            else if (wd_q != '0)
                wd_q <= wd_q - CW'(1);
        end
    end

    // read buffer
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            buf_cnt_q <= '0;
            buf_wr_q <= '0;
            buf_rd_q <= '0;
        end
        else if (clk_en_in)
        begin
            if (buf_in_valid && buf_in_ready)
            begin
                buf_mem[buf_wr_q] <= port_bus_in;
                buf_wr_q <= ptr_next(buf_wr_q);
            end
            if (buf_out_valid && buf_out_ready)
                buf_rd_q <= ptr_next(buf_rd_q);
            buf_cnt_q <= buf_cnt_q + (PW+1)'(buf_in_valid && buf_in_ready)
                - (PW+1)'(buf_out_valid && buf_out_ready);
        end
    end

    // host read data; status frozen for the length of a read
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status_hold_q <= 8'h00;
            host_bus_q <= 8'h00;
        end
        else if (clk_en_in)
        begin
            if (rd_start)
                status_hold_q <= status_live;
            if (rd_active && !epp_hit)
            begin
                if (host_addr_in == `PP_OFS_DATA)
                    host_bus_q <= dir_in ? port_bus_in : data_q;
                else if (host_addr_in == `PP_OFS_STATUS)
                    host_bus_q <= rd_start ? status_live : status_hold_q;
                else if (host_addr_in == `PP_OFS_CONTROL)
                    host_bus_q <= {2'b00, ctl_q};
                else
                    host_bus_q <= 8'h00;
            end
            else if (state_q == pp_pkg::PP_DONE)
                host_bus_q <= cyc_is_write ? cyc_byte_q : buf_mem[buf_rd_q];
        end
    end

    // pins: idle epp mode falls back to standard or bidirectional port
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_bus_out <= 8'h00;
            port_bus_oe_n_out <= 1'b0;
            strobe_out <= 1'b1;
            line_feed_out <= 1'b1;
            init_out <= 1'b0;
            select_in_out <= 1'b1;
            write_indicate_out <= 1'b1;
            data_strobe_out <= 1'b1;
            addr_strobe_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            strobe_out <= !ctl_q[`PP_CT_STROBE];
            line_feed_out <= !ctl_q[`PP_CT_LINE_FEED];
            init_out <= ctl_q[`PP_CT_INIT];
            select_in_out <= !ctl_q[`PP_CT_SELECT];
            if (in_cycle)
            begin
                port_bus_out <= cyc_byte_q;
                port_bus_oe_n_out <= !cyc_is_write;
                // write indicate only moves once wait is low
                if (state_q == pp_pkg::PP_STROBE)
                    write_indicate_out <= !cyc_is_write;
                data_strobe_out <= !((state_q == pp_pkg::PP_STROBE) && !cyc_addr_q);
                addr_strobe_out <= !((state_q == pp_pkg::PP_STROBE) && cyc_addr_q);
            end
            else
            begin
                port_bus_out <= data_q;
                port_bus_oe_n_out <= dir_in;
                write_indicate_out <= 1'b1;
                data_strobe_out <= 1'b1;
                addr_strobe_out <= 1'b1;
            end
        end
    end

    // ready drops the moment an epp access is seen, before the sequencer registers it
    assign host_ready_out = !(in_cycle || (epp_hit && (wr_start || rd_start)));
    assign host_bus_out = host_bus_q;
    assign irq_out = irq_q;

endmodule // pp_port

//--- include/pp_cfg.svh
/*
 * register offsets, field positions, reset values and timing figures of the parallel port block.
 * assumes inclusion by bare name from the design file; holds definitions only.
 */
`ifndef PP_CFG_SVH
`define PP_CFG_SVH

`define PP_OFS_DATA 3'h0
`define PP_OFS_STATUS 3'h1
`define PP_OFS_CONTROL 3'h2
`define PP_OFS_EPP_ADDR 3'h3
`define PP_OFS_EPP_DATA0 3'h4
`define PP_OFS_EPP_DATA1 3'h5
`define PP_OFS_EPP_DATA2 3'h6
`define PP_OFS_EPP_DATA3 3'h7

`define PP_ST_OVERRUN 0
`define PP_ST_FAULT 3
`define PP_ST_ONLINE 4
`define PP_ST_PAPER 5
`define PP_ST_ACK 6
`define PP_ST_NOT_READY 7

`define PP_CT_STROBE 0
`define PP_CT_LINE_FEED 1
`define PP_CT_INIT 2
`define PP_CT_SELECT 3
`define PP_CT_IRQ_ALLOW 4
`define PP_CT_DIR 5
`define PP_CT_WIDTH 6

`define PP_RST_BYTE 8'h00
`define PP_RST_CTL 6'h00

`define PP_CLK_HZ 10000000
`define PP_TIMEOUT_NS 10000
`define PP_TIMEOUT_CYC ((`PP_TIMEOUT_NS * (`PP_CLK_HZ / 1000000)) / 1000)

`endif

//--- include/pp_pkg.sv
/*
 * types of the parallel port block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pp_pkg;
    typedef enum logic [2:0] {
        PP_IDLE,
        PP_PRE_WAIT,
        PP_STROBE,
        PP_DONE,
        PP_HOLD
    } pp_state_e;
endpackage

//--- bench/pp_port_assertions.sv
/* checker of the parallel port host strobes and cable pins.
   assumes binding to pp_port and a single clock domain. */
`timescale 1ns/1ns
module pp_port_assertions #(
    parameter int TIMEOUT_CYCLES = 100
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // host side
    input wire logic epp_mode_in,
    input wire logic [2:0] host_addr_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [7:0] host_bus_out,
    input wire logic host_ready_out,
    input wire logic irq_out,
    // cable side
    input wire logic port_bus_oe_n_out,
    input wire logic write_indicate_out,
    input wire logic data_strobe_out,
    input wire logic addr_strobe_out,
    input wire logic fault_in,
    input wire logic printer_online_in,
    input wire logic paper_out_in,
    input wire logic acknowledge_in,
    input wire logic peripheral_not_ready_in,
    input wire logic peripheral_wait_in
);
    // margin covers the states around the count
    localparam int LIMIT = TIMEOUT_CYCLES + 4;
    logic [15:0] low_q;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
            low_q <= 16'h0000;
        else
            low_q <= host_ready_out ? 16'h0000 : low_q + 16'h0001;
    property p_status;
        $fell(host_rd_n_in) && host_addr_in == 3'h1 |=> host_bus_out[7:1] == {!$past(peripheral_not_ready_in),
            $past(acknowledge_in), $past(paper_out_in), $past(printer_online_in), $past(fault_in), 2'b00};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_status_hold;
        !host_rd_n_in && !$past(host_rd_n_in) && host_addr_in == 3'h1 |=> $stable(host_bus_out);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status changed during read");
    property p_ctl_rsv;
        $fell(host_rd_n_in) && host_addr_in == 3'h2 |=> host_bus_out[7:6] == 2'b00;
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control top bits set");
    property p_ready;
        ($fell(host_wr_n_in) || $fell(host_rd_n_in)) && epp_mode_in && host_addr_in > 3'h2 |-> !host_ready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not pulled low");
    property p_wait_first;
        $fell(data_strobe_out && addr_strobe_out) |-> $past(!peripheral_wait_in);
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("strobe while wait high");
    property p_dir;
        !(data_strobe_out && addr_strobe_out) |-> port_bus_oe_n_out == write_indicate_out;
    endproperty
    a_dir: assert property (p_dir) else $error("bus direction wrong");
    property p_timeout;
        low_q <= LIMIT;
    endproperty
    a_timeout: assert property (p_timeout) else $error("cycle not aborted");
    property p_done;
        $rose(peripheral_wait_in) && !data_strobe_out |-> ##[1:2] (data_strobe_out && host_ready_out);
    endproperty
    a_done: assert property (p_done) else $error("cycle not ended");
    property p_irq;
        $rose(irq_out) |-> $past(acknowledge_in);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without ack");
endmodule // pp_port_assertions

//--- bench/pp_periph_model.sv
/* behavioural peripheral on the cable, answering strobes by wait.
   assumes strobes active low and the port bus resolved here. */
`timescale 1ns/1ns
module pp_periph_model (
    // clock and test controls
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic hold_in,
    input wire logic [2:0] delay_in,
    input wire logic [7:0] rd_byte_in,
    // cable
    input wire logic strobe_n_in,
    input wire logic [7:0] bus_out_in,
    input wire logic bus_oe_n_in,
    output logic wait_out = 1'b0,
    output logic [7:0] bus_in_out,
    // captured write byte
    output logic got_out = 1'b0,
    output logic [7:0] got_byte_out = 8'h00
);
    logic ack = 1'b0;
    logic drv = 1'b0;
    logic [7:0] last = 8'h00;
    int n = 0;
    // released bus shows the inverse of its last level, so no stale byte passes
    assign bus_in_out = !bus_oe_n_in ? bus_out_in : drv ? rd_byte_in : ~last;
    always @(posedge clk_in)
    begin
        // only a driven level is remembered, so a released bus stays steady
        if (!bus_oe_n_in || drv)
            last <= bus_in_out;
        got_out <= 1'b0;
        n <= strobe_n_in ? 0 : n + 1;
        if (hold_in)
            wait_out <= 1'b1;
        else if (!strobe_n_in)
        begin
            if (!stall_in && !wait_out && n >= delay_in)
            begin
                wait_out <= 1'b1;
                ack <= 1'b1;
                drv <= bus_oe_n_in;
                got_byte_out <= bus_out_in;
            end
        end
        else
        begin
            wait_out <= 1'b0;
            got_out <= ack & ~drv;
            ack <= 1'b0;
            drv <= 1'b0;
        end
    end
endmodule // pp_periph_model

//--- bench/pp_port_tb.sv
/* self-checking bench of the parallel port block.
   assumes the peripheral model and the checker are compiled first. */
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module pp_port_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic epp = 1'b0;
    logic ext = 1'b0;
    logic [2:0] ha = 3'h0;
    logic [7:0] hb = 8'h00;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [4:0] pins = 5'h00;
    logic stall = 1'b0;
    logic hold = 1'b0;
    logic [2:0] dly = 3'h0;
    logic [7:0] rdb = 8'h00;
    logic smp = 1'b0;
    wire [7:0] hbo, pbo, pbi, gb;
    wire rdy, irq, oe_n, stb, lf, ini, sel, wi, ds, ast, wt, got;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'h5f5cdc29;
    logic [31:0] v;
    logic [7:0] e;
    logic [7:0] exp_q[$];
    always #50 clk_in = ~clk_in;
    pp_port #(.TIMEOUT_CYCLES(16), .BUF_DEPTH(2)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .epp_mode_in(epp),
        .extended_mode_in(ext), .host_addr_in(ha), .host_bus_in(hb), .host_rd_n_in(rd_n),
        .host_wr_n_in(wr_n), .host_bus_out(hbo), .host_ready_out(rdy), .irq_out(irq),
        .port_bus_in(pbi), .port_bus_out(pbo), .port_bus_oe_n_out(oe_n), .strobe_out(stb),
        .line_feed_out(lf), .init_out(ini), .select_in_out(sel), .write_indicate_out(wi),
        .data_strobe_out(ds), .addr_strobe_out(ast), .fault_in(pins[0]),
        .printer_online_in(pins[1]), .paper_out_in(pins[2]), .acknowledge_in(pins[3]),
        .peripheral_not_ready_in(pins[4]), .peripheral_wait_in(wt));
    pp_periph_model u_per (
        .clk_in(clk_in), .stall_in(stall), .hold_in(hold), .delay_in(dly), .rd_byte_in(rdb),
        .strobe_n_in(ds & ast), .bus_out_in(pbo), .bus_oe_n_in(oe_n), .wait_out(wt),
        .bus_in_out(pbi), .got_out(got), .got_byte_out(gb));
    task automatic finish_test();
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one host access from a rising edge; held until ready is sampled high at a falling edge, data taken at the next rising edge
    task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
        int i;
        i = 0;
        ha <= a;
        hb <= d;
        rd_n <= !r;
        wr_n <= r;
        repeat (2) @(posedge clk_in);
        do @(negedge clk_in); while (rdy !== 1'b1 && ++i < 300);
        if (i >= 300)
            n_errors++;
        smp <= r;
        @(posedge clk_in);
        smp <= 1'b0;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic rdx(input logic [2:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        acc(1'b1, a, 8'h00);
    endtask
    function automatic logic [7:0] st(input logic o);
        return {~pins[4], pins[3:0], 2'b00, o};
    endfunction
    always @(posedge clk_in)
        if (got || smp)
        begin
            e = exp_q.pop_front();
            `CHK(smp ? hbo : gb, e)
        end
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rdx(3'h0, 8'h00);
        rdx(3'h2, 8'h00);
        rdx(3'h5, 8'h00);
        repeat (4)
        begin
            v = $random(seed);
            pins <= v[12:8];
            acc(1'b0, 3'h0, v[7:0]);
            rdx(3'h0, v[7:0]);
            acc(1'b0, 3'h2, v[7:0]);
            rdx(3'h2, {2'b00, v[5:0]});
            `CHK({sel, ini, lf, stb}, {~v[3], v[2], ~v[1:0]})
            // pins move after the read starts; the frozen status must not follow
            fork
                rdx(3'h1, st(1'b0));
                begin
                    @(posedge clk_in);
                    pins <= ~pins;
                end
            join
        end
        ext <= 1'b1;
        acc(1'b0, 3'h2, 8'h24);
        `CHK(oe_n, 1'b1)
        // released bus: a data read returns the live pins
        rdx(3'h0, ~v[7:0]);
        ext <= 1'b0;
        repeat (2) @(posedge clk_in);
        `CHK(oe_n, 1'b0)
        pins <= 5'h00;
        acc(1'b0, 3'h2, 8'h10);
        pins <= 5'h08;
        repeat (3) @(posedge clk_in);
        `CHK(irq, 1'b1)
        acc(1'b0, 3'h2, 8'h04);
        pins <= 5'h00;
        repeat (2) @(posedge clk_in);
        pins <= 5'h08;
        repeat (3) @(posedge clk_in);
        `CHK(irq, 1'b0)
        epp <= 1'b1;
        for (int a = 3; a < 8; a++)
        begin
            v = $random(seed);
            dly <= v[18:16];
            rdb <= v[15:8];
            exp_q.push_back(v[7:0]);
            acc(1'b0, a[2:0], v[7:0]);
            rdx(a[2:0], v[15:8]);
        end
        // wait already high: the strobe must not move until it drops
        dly <= 3'h0;
        hold <= 1'b1;
        repeat (2) @(posedge clk_in);
        exp_q.push_back(8'hA5);
        fork
            acc(1'b0, 3'h4, 8'hA5);
            begin
                repeat (5) @(negedge clk_in);
                `CHK(ds, 1'b1)
                `CHK(wi, 1'b1)
                hold <= 1'b0;
            end
        join
        stall <= 1'b1;
        acc(1'b0, 3'h3, 8'h3C);
        stall <= 1'b0;
        rdx(3'h1, st(1'b1));
        acc(1'b0, 3'h1, 8'h00);
        rdx(3'h1, st(1'b1));
        acc(1'b0, 3'h1, 8'h01);
        rdx(3'h1, st(1'b0));
        // direction set: the attempted write runs as a read on the cable
        rdb <= 8'hC3;
        acc(1'b0, 3'h2, 8'h24);
        acc(1'b0, 3'h4, 8'h69);
        `CHK(hbo, 8'hC3)
        // strobe bit set: the read is forced out as a write
        acc(1'b0, 3'h2, 8'h05);
        exp_q.push_back(8'h5A);
        exp_q.push_back(8'h5A);
        acc(1'b1, 3'h4, 8'h5A);
        finish_test();
    end
    initial
    begin
        #2000000;
        n_errors++;
        finish_test();
    end
endmodule // pp_port_tb
bind pp_port pp_port_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .epp_mode_in(epp_mode_in), .host_addr_in(host_addr_in),
    .host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in), .host_bus_out(host_bus_out),
    .host_ready_out(host_ready_out), .irq_out(irq_out), .port_bus_oe_n_out(port_bus_oe_n_out),
    .write_indicate_out(write_indicate_out), .data_strobe_out(data_strobe_out),
    .addr_strobe_out(addr_strobe_out), .fault_in(fault_in), .printer_online_in(printer_online_in),
    .paper_out_in(paper_out_in), .acknowledge_in(acknowledge_in),
    .peripheral_not_ready_in(peripheral_not_ready_in), .peripheral_wait_in(peripheral_wait_in));
